// >>> rtl/digital_input_event_unit.sv
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module digital_input_event_unit #(
  parameter int unsigned SEC_CYCLES = din_event_pkg::CLK_HZ,      // Clock cycles per second
  parameter int unsigned HR_SECONDS = din_event_pkg::SEC_PER_HR    // Seconds per hour
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 din_pin,        // Raw sensor input
  input  wire logic                 log_tick,       // General log interval pulse
  input  wire logic                 day_tick,       // Configured time of day reached
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      alarm_active,   // Unit in alarm state
  output logic                      measure_req,    // Measure all sensors, pulse
  output logic                      picture_req,    // Take picture, pulse
  output logic                      log_req,        // Timestamped log entry, pulse
  output logic                      output_req,     // Start data output, pulse
  output logic                      irq
);
  import din_event_pkg::*;
  typedef enum logic [1:0] {ST_NORMAL, ST_PRE, ST_ALARM} alarm_st_t;
  logic [31:0] ctrl_reg;        // Role, polarity, edge, action, options
  logic [31:0] delay_reg;       // Trigger delay in seconds
  logic [31:0] alm_cnt_reg;     // Alarms counted
  logic [31:0] total_reg;       // Total on-time, hours
  logic [31:0] interval_reg;    // On-time in current log interval, scaled units
  logic [31:0] int_last_reg;    // Interval on-time captured at last log tick
  logic [31:0] scale_reg;       // Seconds per interval unit
  logic [EV_W-1:0] irq_stat_reg;
  logic [EV_W-1:0] irq_mask_reg;
  logic [EV_W-1:0] ev_now;      // Events this cycle
  logic        sync1_reg;       // First synchroniser stage
  logic        sync2_reg;
  logic        prev_reg;        // Previous synchronised sample
  logic [31:0] sec_div_reg;     // Cycle divider for one-second tick
  logic        sec_tick;
  logic [31:0] delay_cnt_reg;   // Seconds elapsed in pre-alarm
  logic [31:0] sec_acc_reg;     // Active seconds toward next hour
  logic [31:0] int_sec_reg;     // Active seconds toward next scaled unit
  alarm_st_t   alarm_st_reg;
  logic        level_reg;       // Logged input level
  role_t       role;
  logic        act_lvl;         // Input is active after polarity
  logic        rise;
  logic        fall;
  logic        sel_edge;
  // AXI holding state
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_go;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic wr_hit(input logic go, input logic [31:0] a, input logic [7:0] ofs);
    return go && (a[7:0] == ofs) && (a[31:8] == 24'h000000);
  endfunction
  // Two-stage synchroniser, then edge detection on stage two only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= din_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign role     = role_t'(ctrl_reg[CTRL_ROLE_LSB +: 2]);
  // Polarity makes pull-up and pull-down sensors look alike to the alarm and on-time logic; edges and logged level stay raw
  assign act_lvl  = ctrl_reg[CTRL_ACT_HIGH] ? sync2_reg : ~sync2_reg;
  assign rise     = sync2_reg & ~prev_reg;
  assign fall     = ~sync2_reg & prev_reg;
  assign sel_edge = ctrl_reg[CTRL_EDGE_FALL] ? fall : rise;

  // One-second enable from the system clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sec_div_reg <= 32'h0000_0000;
    end else if (sec_div_reg >= SEC_CYCLES - 1) begin
      sec_div_reg <= 32'h0000_0000;
    end else begin
      sec_div_reg <= sec_div_reg + 32'h0000_0001;
    end
  end
  assign sec_tick = (sec_div_reg >= SEC_CYCLES - 1);

  // Alarm state machine
  always_ff @(posedge clk_sys) begin
    if (!rst_n || role != ROLE_ALARM) begin
      alarm_st_reg  <= ST_NORMAL;
      delay_cnt_reg <= 32'h0000_0000;
    end else begin
      unique case (alarm_st_reg)
        ST_NORMAL: begin
          delay_cnt_reg <= 32'h0000_0000;
          if (act_lvl) begin
            alarm_st_reg <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (!act_lvl) begin
            alarm_st_reg <= ST_NORMAL;
          end else if (delay_cnt_reg >= delay_reg) begin
            alarm_st_reg <= ST_ALARM;
          end else if (sec_tick) begin
            delay_cnt_reg <= delay_cnt_reg + 32'h0000_0001;
          end
        end
        ST_ALARM: begin
          if (!act_lvl) begin
            alarm_st_reg <= ST_NORMAL;
          end
        end
        default: alarm_st_reg <= ST_NORMAL;
      endcase
    end
  end
  logic alarm_enter;
  assign alarm_enter = (role == ROLE_ALARM) && (alarm_st_reg == ST_PRE) && act_lvl
                       && (delay_cnt_reg >= delay_reg);
  // Event vector for the interrupt status
  always_comb begin
    ev_now             = '0;
    ev_now[EV_ALARM]   = alarm_enter;
    ev_now[EV_TRIGGER] = (role == ROLE_TRIGGER) && sel_edge;
    ev_now[EV_TRANS]   = (role != ROLE_OFF) && (rise || fall);
    ev_now[EV_LOG]     = log_tick;
  end

  // Request pulses out of the block; all registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      measure_req  <= 1'b0;
      picture_req  <= 1'b0;
      log_req      <= 1'b0;
      output_req   <= 1'b0;
      alarm_active <= 1'b0;
      level_reg    <= 1'b0;
    end else begin
      alarm_active <= (alarm_st_reg == ST_ALARM);
      measure_req  <= alarm_enter
                      || (ev_now[EV_TRIGGER] && ctrl_reg[CTRL_ACTION_LSB +: 2] == ACT_MEASURE);
      picture_req  <= ev_now[EV_TRIGGER] && ctrl_reg[CTRL_ACTION_LSB +: 2] == ACT_PICTURE;
      // Log each alarm-input change, each state transition and, in state role, each log interval
      log_req      <= ((role == ROLE_ALARM || role == ROLE_STATE) && (rise || fall))
                      || (role == ROLE_STATE && log_tick)
                      || (ev_now[EV_TRIGGER] && ctrl_reg[CTRL_ACTION_LSB +: 2] == ACT_LOG);
      output_req   <= (role == ROLE_ALARM && ctrl_reg[CTRL_DIRECT_OUT] && (rise || fall))
                      || (ev_now[EV_TRIGGER] && ctrl_reg[CTRL_ACTION_LSB +: 2] == ACT_OUTPUT);
      if (log_tick || rise || fall) begin
        level_reg <= sync2_reg;
      end
    end
  end

  // On-time accumulation; software writes take priority over counting
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      total_reg    <= 32'h0000_0000;
      sec_acc_reg  <= 32'h0000_0000;
      interval_reg <= 32'h0000_0000;
      int_sec_reg  <= 32'h0000_0000;
      int_last_reg <= 32'h0000_0000;
    end else begin
      if (wr_hit(wr_go, aw_addr_reg, OFS_TOTAL)) begin
        total_reg   <= merge(total_reg, w_data_reg, w_strb_reg);
        sec_acc_reg <= 32'h0000_0000;
      end else if (day_tick && ctrl_reg[CTRL_DAILY_CLR]) begin
        total_reg   <= 32'h0000_0000;
        sec_acc_reg <= 32'h0000_0000;
      end else if (role == ROLE_STATE && act_lvl && sec_tick) begin
        if (sec_acc_reg >= HR_SECONDS - 1) begin
          sec_acc_reg <= 32'h0000_0000;
          total_reg   <= total_reg + 32'h0000_0001;
        end else begin
          sec_acc_reg <= sec_acc_reg + 32'h0000_0001;
        end
      end
      if (log_tick) begin
        int_last_reg <= interval_reg;
        interval_reg <= 32'h0000_0000;
        int_sec_reg  <= 32'h0000_0000;
      end else if (role == ROLE_STATE && act_lvl && sec_tick) begin
        if (int_sec_reg + 32'h0000_0001 >= scale_reg) begin
          int_sec_reg  <= 32'h0000_0000;
          interval_reg <= interval_reg + 32'h0000_0001;
        end else begin
          int_sec_reg  <= int_sec_reg + 32'h0000_0001;
        end
      end
    end
  end

  // Alarm counter: software write overrides, else count each alarm
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alm_cnt_reg <= 32'h0000_0000;
    end else if (wr_hit(wr_go, aw_addr_reg, OFS_ALMCNT)) begin
      alm_cnt_reg <= merge(alm_cnt_reg, w_data_reg, w_strb_reg);
    end else if (alarm_enter) begin
      alm_cnt_reg <= alm_cnt_reg + 32'h0000_0001;
    end
  end

  // Write channel capture, either order
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // Ready flops track a free slot one edge ahead; a finishing write frees both
      s_axi_awready <= wr_go || !(aw_held_reg || (s_axi_awvalid && s_axi_awready));
      s_axi_wready  <= wr_go || !(w_held_reg || (s_axi_wvalid && s_axi_wready));
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg[7:0] <= OFS_EVENT && aw_addr_reg[31:8] == 24'h000000
                         && aw_addr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  // Plain configuration registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg     <= CTRL_RESET;
      delay_reg    <= 32'h0000_0000;
      scale_reg    <= SCALE_RESET;
      irq_mask_reg <= '0;
    end else begin
      if (wr_hit(wr_go, aw_addr_reg, OFS_CTRL))     ctrl_reg     <= merge(ctrl_reg, w_data_reg, w_strb_reg);
      if (wr_hit(wr_go, aw_addr_reg, OFS_DELAY))    delay_reg    <= merge(delay_reg, w_data_reg, w_strb_reg);
      if (wr_hit(wr_go, aw_addr_reg, OFS_SCALE))    scale_reg    <= merge(scale_reg, w_data_reg, w_strb_reg);
      if (wr_hit(wr_go, aw_addr_reg, OFS_IRQ_MASK)) irq_mask_reg <= w_data_reg[EV_W-1:0];
    end
  end

  // Sticky status: new events win over write-one-to-clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      if (wr_hit(wr_go, aw_addr_reg, OFS_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~w_data_reg[EV_W-1:0]) | ev_now;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_now;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read channel, one cycle to answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        if (s_axi_araddr[31:8] != 24'h000000 || s_axi_araddr[1:0] != 2'h0) begin
          s_axi_rresp <= RESP_SLVERR;
          s_axi_rdata <= 32'h0000_0000;
        end else begin
          unique case (s_axi_araddr[7:0])
            OFS_CTRL:     s_axi_rdata <= ctrl_reg;
            OFS_DELAY:    s_axi_rdata <= delay_reg;
            OFS_ALMCNT:   s_axi_rdata <= alm_cnt_reg;
            OFS_TOTAL:    s_axi_rdata <= total_reg;
            OFS_INTERVAL: s_axi_rdata <= int_last_reg;
            OFS_SCALE:    s_axi_rdata <= scale_reg;
            OFS_STATUS:   s_axi_rdata <= {28'h0000000, level_reg, alarm_st_reg, act_lvl};
            OFS_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_reg};
            OFS_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask_reg};
            OFS_EVENT:    s_axi_rdata <= interval_reg;
            default: begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= RESP_SLVERR;
            end
          endcase
        end
      end
    end
  end

  // Checks
  sequence pre_hold_s;
    alarm_st_reg == ST_PRE && act_lvl;
  endsequence
  chk_enter_via_pre: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(alarm_st_reg == ST_ALARM) |-> $past(alarm_st_reg) == ST_PRE)
    else $error("alarm entered without pre-alarm");
  chk_delay_met: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(alarm_st_reg == ST_ALARM) |-> $past(delay_cnt_reg) >= $past(delay_reg))
    else $error("alarm before delay elapsed");
  chk_drop_to_normal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (alarm_st_reg == ST_PRE && !act_lvl && role == ROLE_ALARM) |=> alarm_st_reg == ST_NORMAL)
    else $error("pre-alarm did not abort");
  chk_count_alarm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (alarm_enter && !wr_go) |=> alm_cnt_reg == $past(alm_cnt_reg) + 32'h0000_0001)
    else $error("alarm count not incremented");
  chk_alarm_measure: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pre_hold_s ##0 alarm_enter |=> measure_req)
    else $error("no measure on alarm");
  chk_direct_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (role == ROLE_ALARM && ctrl_reg[CTRL_DIRECT_OUT] && (rise || fall)) |=> output_req)
    else $error("direct output missed");
  chk_one_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(picture_req) |-> $past(role == ROLE_TRIGGER
      && (ctrl_reg[CTRL_EDGE_FALL] ? (prev_reg && !sync2_reg) : (sync2_reg && !prev_reg))))
    else $error("trigger on wrong edge");
  chk_trans_log: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (role == ROLE_STATE && (rise || fall)) |=> log_req && level_reg == $past(sync2_reg))
    else $error("transition not logged");
endmodule

// >>> rtl/din_event_pkg.sv
package din_event_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DELAY    = 8'h04;
  localparam logic [7:0] OFS_ALMCNT   = 8'h08;
  localparam logic [7:0] OFS_TOTAL    = 8'h0C;
  localparam logic [7:0] OFS_INTERVAL = 8'h10;
  localparam logic [7:0] OFS_SCALE    = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_EVENT    = 8'h24;
  // Control fields
  localparam int CTRL_ROLE_LSB    = 0;  // 2 bits
  localparam int CTRL_ACT_HIGH    = 2;
  localparam int CTRL_EDGE_FALL   = 3;
  localparam int CTRL_ACTION_LSB  = 4;  // 2 bits
  localparam int CTRL_DIRECT_OUT  = 6;
  localparam int CTRL_DAILY_CLR   = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  // Interrupt / event bits
  localparam int EV_ALARM   = 0;
  localparam int EV_TRIGGER = 1;
  localparam int EV_TRANS   = 2;
  localparam int EV_LOG     = 3;
  localparam int EV_W       = 4;
  // Time base
  localparam int CLK_HZ     = 25_000_000;
  localparam int SEC_PER_HR = 3600;
  // Default scale: seconds
  localparam logic [31:0] SCALE_RESET = 32'h0000_0001;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ROLE_OFF, ROLE_ALARM, ROLE_TRIGGER, ROLE_STATE} role_t;
  typedef enum logic [1:0] {ACT_MEASURE, ACT_PICTURE, ACT_LOG, ACT_OUTPUT} action_t;
endpackage

// >>> tb/digital_input_event_unit_bench.sv
`timescale 1ns/1ps
module digital_input_event_unit_bench;
  import din_event_pkg::*;
  localparam int SC = 4;  // Shortened second, in cycles
  localparam int HS = 3;  // Shortened hour, in seconds
  logic        clk_sys, rst_n, contact, din_pin, log_tick, day_tick;
  logic [31:0] awaddr, wdata, araddr, rdata, v;
  logic [31:0] cnt0;  // Alarm count preset by software
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, alarm_active, irq;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  req, req_q;  // Action requests, index matches the action code
  int          rises[4], base[4];
  int          errors, checked;

  switch_sensor_model #(.PULL_UP(1'b0)) u_sensor (.contact_closed(contact), .din_level(din_pin));
  digital_input_event_unit #(.SEC_CYCLES(SC), .HR_SECONDS(HS)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .din_pin(din_pin), .log_tick(log_tick), .day_tick(day_tick),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .alarm_active(alarm_active), .measure_req(req[0]), .picture_req(req[1]),
    .log_req(req[2]), .output_req(req[3]), .irq(irq));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Count request pulses by their rising edge, since a pulse may last several cycles
  always @(posedge clk_sys) begin
    req_q <= req;
    for (int i = 0; i < 4; i++) if (req[i] === 1'b1 && req_q[i] !== 1'b1) rises[i]++;
  end

  // Control word as software would compose it
  function automatic logic [31:0] ctrl_word(int role, int fall, int act, int dout, int daily);
    return 32'(role) | 32'h4 | 32'(fall << CTRL_EDGE_FALL) | 32'(act << CTRL_ACTION_LSB)
         | 32'(dout << CTRL_DIRECT_OUT) | 32'(daily << CTRL_DAILY_CLR);
  endfunction

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Each channel is judged on what stands at a rising edge; release follows by NBA on that edge
  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] rs);
    logic b;
    int   n;
    b = 1'b0;
    n = 0;
    rs = 2'h3;
    @(posedge clk_sys);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 50) begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        b = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
    if (!b) chk("write answer", 1, 0);
  endtask

  // Read data and response are taken at the edge where rvalid is seen
  task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic rv;
    int   n;
    rv = 1'b0;
    n = 0;
    d = 32'h0;
    rs = 2'h3;
    @(posedge clk_sys);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rv && n < 50) begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rv = 1'b1;
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
    if (!rv) chk("read answer", 1, 0);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Sensor asserts for n cycles, then releases
  task automatic hold(int n);
    contact <= 1'b1;
    idle(n);
    contact <= 1'b0;
  endtask

  task automatic tick_log;
    log_tick <= 1'b1;
    idle(1);
    log_tick <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: the whole sequence needs about 300 cycles
  initial begin
    idle(20000);
    errors++;
    test_done();
  end

  initial begin
    rst_n = 1'b0; contact = 1'b0; log_tick = 1'b0; day_tick = 1'b0;
    awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    void'($urandom(2882));
    idle(10);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    rd(OFS_CTRL, v, r);      chk("ctrl reset", CTRL_RESET, v);
    rd(OFS_SCALE, v, r);     chk("scale reset", SCALE_RESET, v);
    rd(8'h40, v, r);         chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
    wr(8'h40, 32'h1, r);     chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
    $display("test registers done");
    // Alarm role: short glitch must not alarm, long one must
    wr(OFS_CTRL, ctrl_word(1, 0, 0, 1, 0), r);
    wr(OFS_DELAY, 32'h2, r);
    cnt0 = $urandom & 32'h00FF_FFFF;
    wr(OFS_ALMCNT, cnt0, r);
    base = rises;
    hold(1 + $urandom % 4);
    idle(20);
    chk("alarm after glitch", 0, 32'(alarm_active));
    chk("measure after glitch", base[0], rises[0]);
    // The glitch's own edges still ask for output and log; count afresh from here
    base = rises;
    hold(3 * SC + 12);
    chk("alarm raised", 1, 32'(alarm_active));
    idle(10);
    rd(OFS_ALMCNT, v, r);    chk("alarm count", cnt0 + 1, v);
    chk("alarm change logged", base[2] + 2, rises[2]);
    chk("measure request", base[0] + 1, rises[0]);
    chk("direct output both edges", base[3] + 2, rises[3]);
    $display("test alarm done");
    // Trigger role: every action on the rising edge
    for (int a = 0; a < 4; a++) begin
      wr(OFS_CTRL, ctrl_word(2, 0, a, 0, 0), r);
      base = rises;
      hold(6);
      idle(8);
      for (int i = 0; i < 4; i++) chk("trigger action", base[i] + (i == a), rises[i]);
    end
    // Falling edge: nothing on press, one request on release
    wr(OFS_CTRL, ctrl_word(2, 1, ACT_LOG, 0, 0), r);
    base = rises;
    contact <= 1'b1;
    idle(8);
    chk("no fire on rise", base[2], rises[2]);
    contact <= 1'b0;
    idle(8);
    chk("fire on fall", base[2] + 1, rises[2]);
    $display("test trigger done");
    // State role: hours of active time, then daily clear
    wr(OFS_CTRL, ctrl_word(3, 0, 0, 0, 1), r);
    wr(OFS_TOTAL, 32'h0, r);
    hold(10 * SC);
    idle(6);
    rd(OFS_TOTAL, v, r);     chk("total hours", 32'(10 / HS), v);
    day_tick <= 1'b1;
    idle(1);
    day_tick <= 1'b0;
    idle(2);
    rd(OFS_TOTAL, v, r);     chk("daily clear", 0, v);
    // Interval on-time in seconds and logged level
    wr(OFS_IRQ_STAT, 32'hF, r);
    wr(OFS_IRQ_MASK, 32'(1 << EV_LOG), r);
    tick_log();
    contact <= 1'b1;
    idle(5 * SC);
    tick_log();
    idle(3);
    rd(OFS_INTERVAL, v, r);  chk("interval seconds", 1, 32'(v >= 4 && v <= 6));
    rd(OFS_STATUS, v, r);    chk("logged level", 1, 32'(v[3]));
    contact <= 1'b0;
    chk("irq on log", 1, 32'(irq));
    wr(OFS_IRQ_STAT, 32'(1 << EV_LOG), r);
    idle(3);
    chk("irq cleared", 0, 32'(irq));
    $display("test state done");
    test_done();
  end
endmodule

// >>> tb/switch_sensor_model.sv
`timescale 1ns/1ps
// Switching sensor or contact on the digital input, with the port's bias resistor
module switch_sensor_model #(
  parameter bit PULL_UP = 1'b0  // 1: internal pull-up, 0: internal pull-down
) (
  input  wire logic contact_closed,  // Sensor asserts its event
  output logic      din_level        // Level seen at the input pin
);
  // Pull-up: the sensor sinks the pin to ground; pull-down: it drives it high
  // The released pin rests at the bias level, never at the last driven value
  assign din_level = contact_closed ? !PULL_UP : PULL_UP;
endmodule
